/* common/tcc_regs.svh */
/*
  Constants of the timer/counter core: prescaler ratios, counter limits and
  reset values. Assumes it is included by bare name before the package.
*/
`ifndef TCC_REGS_SVH
`define TCC_REGS_SVH

// Prescaler ratios, indexed by divider_select.
`define TCC_RATIO_0 11'h001
`define TCC_RATIO_1 11'h002
`define TCC_RATIO_2 11'h004
`define TCC_RATIO_3 11'h008
`define TCC_RATIO_4 11'h010
`define TCC_RATIO_5 11'h040
`define TCC_RATIO_6 11'h100
`define TCC_RATIO_7 11'h400

// Counter limits per counter width.
`define TCC_MAX8      32'h000000FF
`define TCC_MAX16     32'h0000FFFF
`define TCC_MAX32     32'hFFFFFFFF
`define TCC_COUNT_RST 32'h00000000
`define TCC_TOP8_MASK 32'h000000FF

`endif

/* common/tcc_pkg.sv */
/*
  Types of the timer/counter core: configuration enumerations, the command
  set, the run states and the enable-protected configuration record.
  Assumes nothing of its surroundings.
*/
package tcc_pkg;
  typedef enum logic [1:0] {TCC_W16, TCC_W8, TCC_W32, TCC_WRSV} tcc_width_t;
  typedef enum logic [1:0] {TCC_PLAIN_TOGGLE, TCC_MATCHED_TOGGLE, TCC_PLAIN_PULSE,
                            TCC_MATCHED_PULSE} tcc_wave_t;
  typedef enum logic [1:0] {TCC_SYNC_GCLK, TCC_SYNC_PRESC, TCC_SYNC_RESYNC,
                            TCC_SYNC_RSV} tcc_sync_t;
  typedef enum logic [2:0] {TCC_EV_OFF, TCC_EV_RETRIGGER, TCC_EV_COUNT, TCC_EV_START,
                            TCC_EV_CAPTURE, TCC_EV_RSV5, TCC_EV_RSV6, TCC_EV_RSV7} tcc_evact_t;
  typedef enum logic [1:0] {TCC_CMD_NONE, TCC_CMD_RETRIGGER, TCC_CMD_STOP,
                            TCC_CMD_RSV} tcc_cmd_t;
  typedef enum logic [1:0] {TCC_IDLE, TCC_WAIT, TCC_RUN, TCC_HALT} tcc_state_t;
  typedef struct packed {
    tcc_width_t width;
    tcc_wave_t  wave;
    logic [2:0] div;
    tcc_sync_t  sync;
    tcc_evact_t evact;
  } tcc_cfg_t;
endpackage

/* common/tcc_presc_if.sv */
/*
  Carrier between the counter core and its prescaler. Assumes both ends run
  on core_clk.
*/
`timescale 1ns/1ps
interface tcc_presc_if;
  logic       gtick;
  logic [2:0] sel;
  logic       restart;
  logic       ptick;
  modport core  (output gtick, output sel, output restart, input ptick);
  modport presc (input gtick, input sel, input restart, output ptick);
endinterface

/* logic/tcc_prescaler.sv */
/*
  Prescaler: divides the sampled generic clock ticks by the selected ratio.
  Assumes gtick is a one-cycle pulse per generic clock rising edge on core_clk.
*/
`timescale 1ns/1ps
`include "tcc_regs.svh"
module tcc_prescaler
  import tcc_pkg::*;
(
  input wire logic core_clk,
  input wire logic resetn,
  tcc_presc_if.presc pif
);
  logic [9:0]  cnt_r;
  logic [9:0]  cnt_nxt;
  logic        phase_r;
  logic        phase_nxt;
  logic [10:0] ratio;
  logic [9:0]  half_m1;
  logic        at_half;

  // Ratio lookup from the divider select code.
  function automatic logic [10:0] ratio_of(input logic [2:0] s);
    unique case (s)
      3'h0: ratio_of = `TCC_RATIO_0;
      3'h1: ratio_of = `TCC_RATIO_1;
      3'h2: ratio_of = `TCC_RATIO_2;
      3'h3: ratio_of = `TCC_RATIO_3;
      3'h4: ratio_of = `TCC_RATIO_4;
      3'h5: ratio_of = `TCC_RATIO_5;
      3'h6: ratio_of = `TCC_RATIO_6;
      default: ratio_of = `TCC_RATIO_7;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Count to half the ratio, then toggle; the rising phase is the tick.
  always_comb
  begin
    ratio     = ratio_of(pif.sel);
    half_m1   = ratio[10:1] - 10'h001;
    at_half   = (cnt_r == half_m1);
    cnt_nxt   = cnt_r;
    phase_nxt = phase_r;
    if (pif.restart)
    begin
      cnt_nxt   = 10'h000;
      phase_nxt = 1'b0;
    end
    else if (pif.gtick)
    begin
      cnt_nxt   = at_half ? 10'h000 : cnt_r + 10'h001;
      phase_nxt = at_half ? ~phase_r : phase_r;
    end
    // Ratio one bypasses the divider entirely.
    pif.ptick = (ratio == `TCC_RATIO_0) ? pif.gtick : (pif.gtick && at_half && !phase_r);
  end

  // Registers only.
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      cnt_r   <= 10'h000;
      phase_r <= 1'b0;
    end
    else
    begin
      cnt_r   <= cnt_nxt;
      phase_r <= phase_nxt;
    end
  end

  a_tick_from_gclk: assert property (@(posedge core_clk) disable iff (!resetn)
    pif.ptick |-> pif.gtick) else $error("prescaled tick without generic tick");
endmodule

/* logic/tcc_core.sv */
/*
  Timer/counter core: prescaled or event-driven counter of 8, 16 or 32 bits,
  commands, event actions, two compare/capture channels and waveforms.
  Assumes config and commands come as same-clock ports; the generic clock
  and the event line are asynchronous and are synchronised here.
*/
// Notes on behaviour
// - Prescaler divides by 1 to 1024
// - Sync setting picks prescaler restart and wrap timing
// - Counted events bypass the prescaler
// - Width 8, 16 or 32; only 8-bit has top limit
// - Odd instance in 32-bit mode is inert follower
// - Up wraps to zero, down reloads top, single_run stops
// - Setter selects down, clearer selects up
// - Wrap sets flag, optional wrap event
// - Count writable, kept across enable
// - Stop holds count, clears waves, sets halted
// - Retrigger wraps running, resumes stopped counter
// - Retrigger action waits for first event
// - Count action steps once per event
// - Start action waits; events while running ignored
// - Match flag set on counter step tick
// - Plain modes use top limit or maximum
// - Toggle on match; matched toggle uses channel zero
// - Pulse mode sets/clears by direction
// - Matched pulse: negative pulse on wrap
// - Missed lower top lets counter run to maximum
// - Per-channel inversion before the pin
// - Configuration locked while enabled
// - Capture while flag set raises overrun
`timescale 1ns/1ps
`include "tcc_regs.svh"
module tcc_core
  import tcc_pkg::*;
#(
  parameter bit ODD_INSTANCE = 1'b0
)
(
  input  wire logic             core_clk,
  input  wire logic             resetn,
  input  wire logic             generic_counter_clock,
  input  wire logic             event_in,
  input  wire logic             enable,
  input  wire tcc_width_t       counter_width_select,
  input  wire tcc_wave_t        waveform_select,
  input  wire logic [2:0]       divider_select,
  input  wire tcc_sync_t        divider_sync_select,
  input  wire tcc_evact_t       event_action_select,
  input  wire logic             timer_event_input_enable,
  input  wire logic             wrap_event_enable,
  input  wire logic [1:0]       channel_event_enable,
  input  wire logic [1:0]       channel_irq_enable,
  input  wire logic [1:0]       output_invert,
  input  wire logic [1:0]       capture_channel_enable,
  input  wire logic [1:0]       control_b_setter,
  input  wire logic [1:0]       control_b_clearer,
  input  wire tcc_cmd_t         command,
  input  wire logic             count_write,
  input  wire logic [31:0]      count_write_data,
  input  wire logic [7:0]       top_limit_value,
  input  wire logic [1:0][31:0] channel_match_value,
  input  wire logic             wrap_flag_clear,
  input  wire logic [1:0]       channel_match_flag_clear,
  input  wire logic             capture_overrun_clear,
  output logic [31:0]           count_value,
  output logic [1:0][31:0]      capture_value,
  output logic [1:0]            wave_out,
  output logic                  wrap_flag,
  output logic                  wrap_event,
  output logic [1:0]            channel_match_flag,
  output logic [1:0]            channel_event,
  output logic [1:0]            channel_irq,
  output logic                  capture_overrun_flag,
  output logic                  halted,
  output logic                  follower_status,
  output logic                  count_down,
  output logic                  single_run
);
  tcc_presc_if pif ();

  logic [2:0]       gsync_r;
  logic [2:0]       gsync_nxt;
  logic [2:0]       esync_r;
  logic [2:0]       esync_nxt;
  logic             en_r;
  tcc_cfg_t         cfg_r;
  tcc_cfg_t         cfg_nxt;
  tcc_state_t       state_r;
  tcc_state_t       state_nxt;
  logic [31:0]      cnt_r;
  logic [31:0]      cnt_nxt;
  logic             dir_r;
  logic             dir_nxt;
  logic             one_r;
  logic             one_nxt;
  logic             wrapf_r;
  logic             wrapf_nxt;
  logic             wrapev_r;
  logic             wrapev_nxt;
  logic [1:0]       mflag_r;
  logic [1:0]       mflag_nxt;
  logic [1:0]       mev_r;
  logic [1:0]       mev_nxt;
  logic [1:0]       irq_r;
  logic [1:0]       irq_nxt;
  logic             ovr_r;
  logic             ovr_nxt;
  logic [1:0][31:0] cap_r;
  logic [1:0][31:0] cap_nxt;
  logic [1:0]       wave_r;
  logic [1:0]       wave_nxt;
  logic [1:0]       pin_r;
  logic [1:0]       pin_nxt;
  logic             follower;
  logic [31:0]      mask;
  logic [31:0]      top;
  logic             up;
  logic             at_end;
  logic             evt_pulse;
  logic             step_tick;
  logic             running;
  logic             retrig;
  logic             start_ev;
  logic             stop_cmd;
  logic             wr;
  logic             wrap_hit;
  logic             step_hit;
  logic             cap_ev;
  logic [1:0]       match_hit;

  // Counter range mask for a width setting; reserved code acts as 16-bit.
  function automatic logic [31:0] wmask(input tcc_width_t w);
    unique case (w)
      TCC_W8:  wmask = `TCC_MAX8;
      TCC_W32: wmask = `TCC_MAX32;
      default: wmask = `TCC_MAX16;
    endcase
  endfunction

  // Top value: channel zero in matched modes, else limit or maximum.
  function automatic logic [31:0] top_of(input tcc_cfg_t c, input logic [7:0] lim,
                                         input logic [31:0] cc0);
    if (c.wave == TCC_MATCHED_TOGGLE || c.wave == TCC_MATCHED_PULSE)
      top_of = cc0 & wmask(c.width);
    else if (c.width == TCC_W8)
      top_of = {24'h000000, lim} & `TCC_TOP8_MASK;
    else
      top_of = wmask(c.width);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Two-stage synchronisers for the generic clock and the event line.
  always_comb
  begin
    gsync_nxt = {gsync_r[1:0], generic_counter_clock};
    esync_nxt = {esync_r[1:0], event_in};
  end

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      gsync_r <= 3'h0;
      esync_r <= 3'h0;
    end
    else
    begin
      gsync_r <= gsync_nxt;
      esync_r <= esync_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Enable-protected configuration is taken only while the timer was off,
  // so a write together with enable rising still lands.
  always_comb
  begin
    cfg_nxt = cfg_r;
    if (!en_r)
      cfg_nxt = '{counter_width_select, waveform_select, divider_select,
                  divider_sync_select, event_action_select};
  end

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      en_r  <= 1'b0;
      cfg_r <= '{TCC_W16, TCC_PLAIN_TOGGLE, 3'h0, TCC_SYNC_GCLK, TCC_EV_OFF};
    end
    else
    begin
      en_r  <= enable;
      cfg_r <= cfg_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Step decode shared by counter, flags and waveforms.
  always_comb
  begin
    follower  = ODD_INSTANCE && cfg_r.width == TCC_W32;
    mask      = wmask(cfg_r.width);
    top       = top_of(cfg_r, top_limit_value, channel_match_value[0]);
    up        = !dir_r;
    // Equality only: a top lowered below the count is passed by.
    at_end    = up ? (cnt_r == top) : (cnt_r == `TCC_COUNT_RST);
    // Only the second and third event stages are read, so the first stage may settle.
    evt_pulse = esync_r[1] & ~esync_r[2] & timer_event_input_enable;
    if (cfg_r.evact == TCC_EV_COUNT)
      step_tick = evt_pulse;
    else if (at_end && cfg_r.sync != TCC_SYNC_PRESC)
      step_tick = pif.gtick;
    else
      step_tick = pif.ptick;
    running  = state_r == TCC_RUN && !follower;
    retrig   = command == TCC_CMD_RETRIGGER ||
               (evt_pulse && cfg_r.evact == TCC_EV_RETRIGGER);
    start_ev = evt_pulse && cfg_r.evact == TCC_EV_START;
    stop_cmd = command == TCC_CMD_STOP;
    wr       = count_write && !follower;
    step_hit = running && step_tick && !wr && !retrig && !stop_cmd;
    wrap_hit = step_hit && at_end;
    cap_ev   = evt_pulse && cfg_r.evact == TCC_EV_CAPTURE && en_r && !follower;
    pif.gtick   = gsync_r[1] & ~gsync_r[2];
    pif.sel     = cfg_r.div;
    pif.restart = !en_r || (wrap_hit && cfg_r.sync == TCC_SYNC_RESYNC);
  end

  // One comparator per channel.
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++)
    begin : g_cmp
      assign match_hit[gi] = step_hit && cnt_r == (channel_match_value[gi] & mask);
    end
  endgenerate

  tcc_prescaler u_presc (
    .core_clk (core_clk),
    .resetn   (resetn),
    .pif      (pif.presc)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Run state, direction, single_run and the counter value.
  always_comb
  begin
    state_nxt = state_r;
    unique case (state_r)
      TCC_IDLE:
        if (enable)
          state_nxt = (cfg_nxt.evact == TCC_EV_RETRIGGER || cfg_nxt.evact == TCC_EV_START)
                      ? TCC_WAIT : TCC_RUN;
      TCC_WAIT, TCC_HALT:
        if (retrig || start_ev)
          state_nxt = TCC_RUN;
      TCC_RUN:
        if (stop_cmd)
          state_nxt = TCC_HALT;
        else if (wrap_hit && one_r)
          state_nxt = TCC_HALT;
    endcase
    if (!enable || follower)
      state_nxt = TCC_IDLE;
    dir_nxt = dir_r;
    one_nxt = one_r;
    if (control_b_setter[0])
      dir_nxt = 1'b1;
    else if (control_b_clearer[0])
      dir_nxt = 1'b0;
    if (control_b_setter[1])
      one_nxt = 1'b1;
    else if (control_b_clearer[1])
      one_nxt = 1'b0;
    cnt_nxt = cnt_r;
    if (wr)
      cnt_nxt = count_write_data & mask;
    else if ((retrig && running && !stop_cmd) || wrap_hit)
      cnt_nxt = up ? `TCC_COUNT_RST : top;
    else if (step_hit)
      cnt_nxt = (up ? cnt_r + 32'h00000001 : cnt_r - 32'h00000001) & mask;
  end

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      state_r <= TCC_IDLE;
      dir_r   <= 1'b0;
      one_r   <= 1'b0;
      cnt_r   <= `TCC_COUNT_RST;
    end
    else
    begin
      state_r <= state_nxt;
      dir_r   <= dir_nxt;
      one_r   <= one_nxt;
      cnt_r   <= cnt_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Flags and events; a hardware set always beats a same-cycle clear.
  always_comb
  begin
    wrapf_nxt  = wrap_hit | (wrapf_r & ~wrap_flag_clear);
    wrapev_nxt = wrap_hit & wrap_event_enable;
    ovr_nxt    = ovr_r & ~capture_overrun_clear;
    cap_nxt    = cap_r;
    for (int i = 0; i < 2; i++)
    begin
      mflag_nxt[i] = mflag_r[i] & ~channel_match_flag_clear[i];
      mev_nxt[i]   = 1'b0;
      if (match_hit[i] && !capture_channel_enable[i])
      begin
        mflag_nxt[i] = 1'b1;
        mev_nxt[i]   = channel_event_enable[i];
      end
      if (cap_ev && capture_channel_enable[i])
      begin
        if (mflag_r[i])
          ovr_nxt = 1'b1;
        else
        begin
          mflag_nxt[i] = 1'b1;
          cap_nxt[i]   = cnt_r;
        end
      end
    end
    irq_nxt = mflag_nxt & channel_irq_enable;
  end

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      wrapf_r  <= 1'b0;
      wrapev_r <= 1'b0;
      mflag_r  <= 2'h0;
      mev_r    <= 2'h0;
      irq_r    <= 2'h0;
      ovr_r    <= 1'b0;
      cap_r    <= '0;
    end
    else
    begin
      wrapf_r  <= wrapf_nxt;
      wrapev_r <= wrapev_nxt;
      mflag_r  <= mflag_nxt;
      mev_r    <= mev_nxt;
      irq_r    <= irq_nxt;
      ovr_r    <= ovr_nxt;
      cap_r    <= cap_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Waveforms. Waves go low before inversion whenever the counter will not be running,
  // which covers disable, stop, single_run end and the wait for an event.
  always_comb
  begin
    for (int i = 0; i < 2; i++)
    begin
      wave_nxt[i] = wave_r[i];
      if (!enable || follower || state_nxt != TCC_RUN)
        wave_nxt[i] = 1'b0;
      else if (cfg_r.wave == TCC_PLAIN_TOGGLE)
        wave_nxt[i] = wave_r[i] ^ match_hit[i];
      else if (cfg_r.wave == TCC_MATCHED_TOGGLE)
        wave_nxt[i] = wave_r[i] ^ ((i == 0) ? wrap_hit : match_hit[i]);
      else if (cfg_r.wave == TCC_MATCHED_PULSE && i == 0)
        wave_nxt[i] = !wrap_hit;
      else if (wrap_hit || retrig || state_r != TCC_RUN)
        wave_nxt[i] = up;
      else if (match_hit[i])
        wave_nxt[i] = !up;
    end
    // Inversion sits last, so a disabled pin rests at its invert level.
    pin_nxt = wave_nxt ^ output_invert;
  end

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      wave_r <= 2'h0;
      pin_r  <= 2'h0;
    end
    else
    begin
      wave_r <= wave_nxt;
      pin_r  <= pin_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output wiring, all from registers.
  assign count_value          = cnt_r;
  assign capture_value        = cap_r;
  assign wave_out             = pin_r;
  assign wrap_flag            = wrapf_r;
  assign wrap_event           = wrapev_r;
  assign channel_match_flag   = mflag_r;
  assign channel_event        = mev_r;
  assign channel_irq          = irq_r;
  assign capture_overrun_flag = ovr_r;
  assign halted               = state_r == TCC_HALT;
  assign follower_status      = ODD_INSTANCE && cfg_r.width == TCC_W32;
  assign count_down           = dir_r;
  assign single_run           = one_r;

  ////////////////////////////////////////////////////////////////////////////
  // Checks.
  a_stop_halts: assert property (@(posedge core_clk) disable iff (!resetn)
    enable && stop_cmd && running |=> halted && wave_r == 2'h0 && $stable(cnt_r))
    else $error("stop did not halt");
  a_wrap_flag_set: assert property (@(posedge core_clk) disable iff (!resetn)
    wrap_hit |=> wrap_flag && (wrap_event == $past(wrap_event_enable)))
    else $error("wrap flag or event missing");
  a_up_wrap_zero: assert property (@(posedge core_clk) disable iff (!resetn)
    wrap_hit && !dir_r |=> cnt_r == `TCC_COUNT_RST)
    else $error("up count did not wrap to zero");
  a_down_reload: assert property (@(posedge core_clk) disable iff (!resetn)
    wrap_hit && dir_r |=> cnt_r == $past(top))
    else $error("down count did not reload top");
  a_single_run_stop: assert property (@(posedge core_clk) disable iff (!resetn)
    wrap_hit && one_r && enable && !stop_cmd |=> halted && wave_r == 2'h0)
    else $error("single run did not stop");
  a_disabled_low: assert property (@(posedge core_clk) disable iff (!resetn)
    !enable |=> wave_r == 2'h0 && wave_out == $past(output_invert))
    else $error("waves not low while disabled");
  a_cfg_locked: assert property (@(posedge core_clk) disable iff (!resetn)
    en_r && $past(en_r) |-> $stable(cfg_r))
    else $error("configuration changed while enabled");
  a_count_event: assert property (@(posedge core_clk) disable iff (!resetn)
    running && cfg_r.evact == TCC_EV_COUNT && evt_pulse && !at_end && !dir_r && !wr &&
    command == TCC_CMD_NONE |=> cnt_r == (($past(cnt_r) + 32'h00000001) & $past(mask)))
    else $error("count event did not step by one");
  a_overrun_set: assert property (@(posedge core_clk) disable iff (!resetn)
    cap_ev && capture_channel_enable[0] && mflag_r[0] |=> capture_overrun_flag)
    else $error("capture overrun not flagged");
  a_start_ignored: assert property (@(posedge core_clk) disable iff (!resetn)
    running && start_ev && enable && !stop_cmd && !(wrap_hit && one_r) |=> state_r == TCC_RUN)
    else $error("start event disturbed a running counter");
endmodule

/* sim/tcc_far_end.sv */
/* Far-end model: generic counter clock source and event line.
   Assumes core_clk at 40 MHz and requests driven just after its edge. */
`timescale 1ns/1ps
module tcc_far_end
(
  input  wire logic core_clk,
  input  wire logic run,
  input  wire logic fire,
  output logic      gclk,
  output logic      ev
);
  logic [1:0] div_r;
  logic [2:0] ev_n;
  initial
  begin
    div_r = 2'h0;
    ev_n = 3'h0;
  end
  // Clock stands still low outside runs; two cycles high and low meets the pin limit.
  // An event is high three cycles then low at least three, for the two-stage sync.
  always @(posedge core_clk)
  begin
    div_r <= run ? div_r + 2'h1 : 2'h0;
    ev_n <= fire ? 3'h5 : (ev_n != 3'h0 ? ev_n - 3'h1 : 3'h0);
  end
  assign gclk = div_r[1];
  assign ev = ev_n > 3'h2;
endmodule

/* sim/testbench.sv */
/* Self-checking bench of the counter core with a step model.
   Assumes the far-end model and the core share core_clk. */
`timescale 1ns/1ps
module testbench
  import tcc_pkg::*;
;
  logic core_clk, resetn, generic_counter_clock, event_in, enable, run, fire, chk;
  tcc_width_t counter_width_select;
  tcc_wave_t waveform_select;
  tcc_sync_t divider_sync_select;
  tcc_evact_t event_action_select;
  tcc_cmd_t command;
  logic [2:0] divider_select;
  logic timer_event_input_enable, wrap_event_enable, count_write, wrap_flag_clear, capture_overrun_clear;
  logic [1:0] channel_event_enable, channel_irq_enable, output_invert, capture_channel_enable;
  logic [1:0] control_b_setter, control_b_clearer, channel_match_flag_clear;
  logic [1:0] wave_out, channel_match_flag, channel_event, channel_irq;
  logic [31:0] count_write_data, count_value;
  logic [7:0] top_limit_value, lfsr;
  logic [1:0][31:0] channel_match_value, capture_value;
  logic wrap_flag, wrap_event, capture_overrun_flag, halted, follower_status, count_down, single_run;
  int fails, comparisons, prev, top, dir, steps, s0;
  tcc_core uut (.*);
  tcc_far_end far (.core_clk(core_clk), .run(run), .fire(fire), .gclk(generic_counter_clock), .ev(event_in));
  ////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    comparisons++;
    if (got !== exp)
    begin
      fails++;
      $display("Error at %0t: %s got %0h expected %0h", $time, what, got, exp);
    end
  endtask
  task automatic give_verdict;
    $display("Comparisons %0d, mismatches %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // Inputs always change 2 ns after the rising edge.
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
    #2;
  endtask
  function automatic logic [7:0] next_lfsr(input logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction
  task automatic pulse_event;
    fire = 1'b1;
    cyc(1);
    fire = 1'b0;
    cyc(10);
  endtask
  ////////////////////////////////////////////////////////////////////////
  // Every count change must be one step of the wrap sequence; a jump shows a fault.
  always @(posedge core_clk)
    if (chk && count_value !== prev[31:0])
    begin
      steps++;
      if (dir == 0)
        check(count_value, (prev == top) ? 0 : prev + 1, "up step");
      else
        check(count_value, (prev == 0) ? top : prev - 1, "down step");
      check(wrap_event, (dir == 0) ? (prev == top) : (prev == 0), "wrap event");
      check(channel_event, {prev == channel_match_value[1], prev == channel_match_value[0]}, "match event");
      prev = count_value;
    end
  initial
  begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end
  // Cuts a hang short; the whole run needs well under 3000 cycles.
  initial
  begin
    #(25 * 20000);
    fails++;
    give_verdict();
  end
  initial
  begin
    {resetn, enable, run, fire, chk, count_write, wrap_flag_clear, capture_overrun_clear} = 8'h00;
    {control_b_setter, control_b_clearer, channel_match_flag_clear} = 6'h00;
    {channel_event_enable, channel_irq_enable, capture_channel_enable} = 6'h3C;
    {timer_event_input_enable, wrap_event_enable} = 2'h3;
    command = TCC_CMD_NONE;
    count_write_data = 32'h00000000;
    lfsr = next_lfsr(8'h44);
    top = lfsr[3:0] | 4;
    top_limit_value = top[7:0];
    output_invert = lfsr[7:6];
    channel_match_value = {32'h00000001, 32'h00000002};
    counter_width_select = TCC_W8;
    waveform_select = TCC_PLAIN_TOGGLE;
    divider_select = 3'h0;
    divider_sync_select = TCC_SYNC_GCLK;
    event_action_select = TCC_EV_OFF;
    {fails, comparisons, dir, steps} = '0;
    cyc(3);
    resetn = 1'b1;
    check(count_value, 0, "reset count");
    check(wave_out, 0, "reset waves");
    // Up count in 8-bit mode; the width change while enabled must be ignored.
    enable = 1'b1;
    run = 1'b1;
    cyc(2);
    counter_width_select = TCC_W16;
    prev = count_value;
    chk = 1'b1;
    cyc(250);
    check(wrap_flag, 1, "wrap flag");
    check(channel_match_flag[0], 1, "match flag");
    check(channel_irq[0], 1, "match irq");
    check(follower_status, 0, "not follower");
    // Stop holds the count and clears the waves before inversion.
    command = TCC_CMD_STOP;
    counter_width_select = TCC_W8;
    cyc(1);
    command = TCC_CMD_NONE;
    chk = 1'b0;
    cyc(1);
    prev = count_value;
    cyc(20);
    check(halted, 1, "halted");
    check(count_value, prev, "held count");
    check(wave_out, output_invert, "stop waves");
    // Down direction, then a retrigger resumes from the held count.
    control_b_setter = 2'h1;
    wrap_flag_clear = 1'b1;
    cyc(1);
    {control_b_setter, wrap_flag_clear} = 3'h0;
    check(count_down, 1, "down set");
    command = TCC_CMD_RETRIGGER;
    dir = 1;
    chk = 1'b1;
    cyc(1);
    command = TCC_CMD_NONE;
    cyc(250);
    check(wrap_flag, 1, "underflow flag");
    // Single run stops after the next wrap and reloads top.
    control_b_setter = 2'h2;
    cyc(1);
    control_b_setter = 2'h0;
    check(single_run, 1, "single run set");
    for (int i = 0; i < 600 && halted !== 1'b1; i++)
      cyc(1);
    check(halted, 1, "single stop");
    check(count_value, top, "reload top");
    // Count action: each event steps once, with the prescaler at 1024.
    chk = 1'b0;
    enable = 1'b0;
    control_b_clearer = 2'h3;
    cyc(1);
    control_b_clearer = 2'h0;
    check({count_down, single_run}, 0, "control cleared");
    event_action_select = TCC_EV_COUNT;
    divider_select = 3'h7;
    enable = 1'b1;
    dir = 0;
    cyc(2);
    check(count_value, top, "kept count");
    {prev, s0, chk} = {top, steps, 1'b1};
    repeat (3) pulse_event();
    check(steps - s0, 3, "event steps");
    // Start action: the enabled counter waits for an event.
    enable = 1'b0;
    cyc(1);
    event_action_select = TCC_EV_START;
    divider_select = 3'h0;
    enable = 1'b1;
    s0 = steps;
    cyc(60);
    check(steps - s0, 0, "start waits");
    pulse_event();
    pulse_event();
    cyc(60);
    check(steps > s0, 1, "started");
    // Capture on channel 0 with the generic clock stopped, so the count stands still.
    {run, enable} = 2'h0;
    cyc(1);
    event_action_select = TCC_EV_CAPTURE;
    capture_channel_enable = 2'h1;
    channel_match_flag_clear = 2'h3;
    enable = 1'b1;
    cyc(4);
    channel_match_flag_clear = 2'h0;
    pulse_event();
    check(capture_value[0], prev, "captured count");
    check(channel_match_flag[0], 1, "capture flag");
    pulse_event();
    check(capture_overrun_flag, 1, "capture overrun");
    check(capture_value[0], prev, "capture kept");
    give_verdict();
  end
endmodule
